// >>> core/qio_cfg.svh
// Purpose: constants of the quad I/O read link and host register map
// Assumes: included by bare name
// Notes:   definitions only
`ifndef QIO_CFG_SVH
`define QIO_CFG_SVH
`define OPC_QREAD      8'hEB
`define OPC_WREAD      8'hE7
`define OPC_OREAD      8'hE3
`define OPC_SETWRAP    8'h77
`define OPC_BITS       4'h8
`define ADDR_NIBS      4'h6
`define MODE_NIBS      4'h2
`define WRAP_CLKS      4'h8
`define WRAP_HI_CLK    4'h6
`define WRAP_LO_CLK    4'h7
`define DUMMY_QREAD    4'h4
`define DUMMY_WREAD    4'h2
`define DUMMY_OREAD    4'h0
`define CONT_KEEP      2'h2
`define MODE_CONT      8'h20
`define MODE_NORMAL    8'h00
`define WRAP_RESET     3'h1
`define WRAP_OFF_BYTE  8'h10
`define EXIT_WORD      32'hFFFFFFFF
`define SCK_HALF       4'h4
`define REG_CTRL       8'h00
`define REG_ADDR       8'h04
`define REG_LEN        8'h08
`define REG_STATUS     8'h0C
`define REG_RXDATA     8'h10
`define CTRL_GO        0
`define CTRL_CONT      1
`define CTRL_OP_LSB    2
`define CTRL_OP_MSB    4
`endif

// >>> core/qio_pkg.sv
// Purpose: shared types of both link ends
// Assumes: nothing
// Notes:   constants live in qio_cfg.svh
package qio_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [2:0] {
    D_OPC   = 3'b000,
    D_ADDR  = 3'b001,
    D_MODE  = 3'b010,
    D_DUMMY = 3'b011,
    D_DATA  = 3'b100,
    D_WRAP  = 3'b101,
    D_IGN   = 3'b110
  } dev_state_e;
  typedef enum logic [3:0] {
    H_IDLE  = 4'b0000,
    H_OPC   = 4'b0001,
    H_ADDR  = 4'b0010,
    H_MODE  = 4'b0011,
    H_DUMMY = 4'b0100,
    H_DATA  = 4'b0101,
    H_WRAP  = 4'b0110,
    H_EXIT  = 4'b0111,
    H_STOP  = 4'b1000
  } host_state_e;
  typedef enum logic [2:0] {
    OP_QREAD   = 3'b000,
    OP_WREAD   = 3'b001,
    OP_OREAD   = 3'b010,
    OP_SETWRAP = 3'b011,
    OP_EXIT    = 3'b100
  } host_op_e;
endpackage: qio_pkg

// >>> core/qio_link_if.sv
// Purpose: serial quad link between host and flash ends
// Assumes: idle lines float high
// Notes:   io is the resolved wire level
`timescale 1ns/100ps
interface qio_link_if;
  logic       cs_n;
  logic       sclk;
  logic [3:0] host_io_out;
  logic [3:0] host_io_oe;
  logic [3:0] dev_io_out;
  logic [3:0] dev_io_oe;
  logic [3:0] io;
  // Pull-up on undriven lines
  assign io = (host_io_oe & host_io_out) | (dev_io_oe & dev_io_out)
            | ~(host_io_oe | dev_io_oe);
  modport host_mp (output cs_n, output sclk, output host_io_out, output host_io_oe,
                   input io);
  modport dev_mp (input cs_n, input sclk, input io, output dev_io_out,
                  output dev_io_oe);
endinterface: qio_link_if

// >>> core/qio_flash_end.sv
// Purpose: flash-side command logic for quad I/O reads and burst wrap
// Assumes: link pins synchronous to SYS_CLK_IN, SCLK half period >= 4 cycles
// Notes:   array is outside, read one cycle after MEM_RD_OUT
// Function
// - EBh quad read, four dummy clocks
// - Quad reads need quad enable bit
// - Mode byte follows 24-bit address
// - Select pair 10 skips next opcode
// - Other select values restore opcode phase
// - Host releases IO before data
// - E7h: A0 zero, two dummy clocks
// - E3h: A3-0 zero, no dummy clocks
// - Wrap returns to section start until deselect
// - Wrap only for EBh and E7h
// - 77h: opcode, 24 dummy, wrap byte
// - Disable bit clear enables; length field picks size
// - Wrap setting persists, powers up off
// - Host disables wrap after its reset
// - Reserved mode bits are ignored
// - Only quad reads set continuous mode
// - All-ones mode byte exits continuous mode
`timescale 1ns/100ps
`include "qio_cfg.svh"
module qio_flash_end (
  // Clock and reset
  input  wire logic          SYS_CLK_IN,
  input  wire logic          RESET_IN,
  // Serial link
  qio_link_if.dev_mp         LINK,
  // Status register 2 bit
  input  wire logic          QUAD_IO_ENABLE_BIT_IN,
  // Array read port
  output logic [23:0]        MEM_ADDR_OUT,
  output logic               MEM_RD_OUT,
  input  wire qio_pkg::byte_t MEM_DATA_IN,
  // Settings view
  output logic [2:0]         WRAP_SETTING_BITS_OUT,
  output logic               CONT_READ_ACTIVE_OUT
);
  import qio_pkg::*;

  dev_state_e  st_q;
  dev_state_e  st_d;
  logic        sclk_q;
  logic [3:0]  cnt_q;
  logic [7:0]  opc_q;
  logic [7:0]  op_q;
  logic [23:0] addr_q;
  logic [7:0]  mode_q;
  logic [3:0]  wrap_hi_q;
  logic [2:0]  wrap_q;
  logic        cont_q;
  logic [7:0]  data_q;
  logic        lo_q;
  logic        rd_q;
  logic        rd_dly_q;
  logic [3:0]  dout_q;
  logic [3:0]  doe_q;

  // Edge detect; pins are already in this clock domain
  wire         cs_act   = ~LINK.cs_n;
  wire         rise     = cs_act & LINK.sclk & ~sclk_q;
  wire         fall     = cs_act & ~LINK.sclk & sclk_q;
  wire [3:0]   cnt_nxt  = cnt_q + 4'h1;
  wire         adv      = st_d != st_q;

  // Opcode arrives one bit per clock on IO0
  wire [7:0]   opc_nxt  = {opc_q[6:0], LINK.io[0]};
  wire         is_qread = (opc_nxt == `OPC_QREAD) | (opc_nxt == `OPC_WREAD)
                        | (opc_nxt == `OPC_OREAD);
  wire         qread_ok = is_qread & QUAD_IO_ENABLE_BIT_IN;

  // Dummy length per read variant
  wire [3:0]   dummy_n  = (op_q == `OPC_QREAD) ? `DUMMY_QREAD :
                          (op_q == `OPC_WREAD) ? `DUMMY_WREAD :
                          `DUMMY_OREAD;

  // Address nibbles, most significant first
  wire [23:0]  addr_shift = {addr_q[19:0], LINK.io};
  // Misaligned low bits are forced to zero rather than rejected
  wire [23:0]  addr_end = (op_q == `OPC_WREAD) ? {addr_shift[23:1], 1'b0} :
                          (op_q == `OPC_OREAD) ? {addr_shift[23:4], 4'h0} :
                          addr_shift;
  wire [7:0]   mode_nxt = {mode_q[3:0], LINK.io};
  // Only bits 5-4 matter; 7-6 and 3-0 are don't care
  wire         keep_nxt = mode_nxt[5:4] == `CONT_KEEP;

  // Wrap only for the standard and word variants
  wire         wrap_on  = ~wrap_q[0]
                        & ((op_q == `OPC_QREAD) | (op_q == `OPC_WREAD));
  wire [7:0]   wrap_msk = (8'h08 << wrap_q[2:1]) - 8'h01;
  wire [7:0]   lo_inc   = addr_q[7:0] + 8'h01;
  wire [23:0]  addr_inc = wrap_on
                        ? {addr_q[23:8], (addr_q[7:0] & ~wrap_msk) | (lo_inc & wrap_msk)}
                        : addr_q + 24'h000001;

  wire         data_go  = rise & adv & (st_d == D_DATA);
  wire         byte_end = fall & (st_q == D_DATA) & lo_q;

  always_comb begin
    st_d = st_q;
    case (st_q)
      D_OPC: begin
        if (cnt_nxt == `OPC_BITS) begin
          if (opc_nxt == `OPC_SETWRAP) begin
            st_d = D_WRAP;
          end else if (qread_ok) begin
            st_d = D_ADDR;
          end else begin
            st_d = D_IGN;
          end
        end
      end
      D_ADDR: begin
        if (cnt_nxt == `ADDR_NIBS) begin
          st_d = D_MODE;
        end
      end
      D_MODE: begin
        if (cnt_nxt == `MODE_NIBS) begin
          st_d = (dummy_n == `DUMMY_OREAD) ? D_DATA : D_DUMMY;
        end
      end
      D_DUMMY: begin
        if (cnt_nxt == dummy_n) begin
          st_d = D_DATA;
        end
      end
      D_WRAP: begin
        if (cnt_nxt == `WRAP_CLKS) begin
          st_d = D_IGN;
        end
      end
      default: begin
        st_d = st_q;
      end
    endcase
  end

  // Deselect ends any command; continuous mode reenters at the address
  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      st_q <= D_OPC;
    end else if (!cs_act) begin
      st_q <= cont_q ? D_ADDR : D_OPC;
    end else if (rise) begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN || !cs_act) begin
      cnt_q <= 4'h0;
    end else if (rise) begin
      cnt_q <= adv ? 4'h0 : cnt_nxt;
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= LINK.sclk;
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN || !cs_act) begin
      opc_q <= 8'h00;
    end else if (rise && st_q == D_OPC) begin
      opc_q <= opc_nxt;
    end
  end

  // Remembered read replays in continuous mode
  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      op_q <= `OPC_QREAD;
    end else if (rise && st_q == D_OPC && st_d == D_ADDR) begin
      op_q <= opc_nxt;
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      addr_q <= 24'h000000;
    end else if (rise && st_q == D_ADDR) begin
      addr_q <= (st_d == D_MODE) ? addr_end : addr_shift;
    end else if (byte_end) begin
      addr_q <= addr_inc;
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      mode_q <= 8'h00;
    end else if (rise && st_q == D_MODE) begin
      mode_q <= mode_nxt;
    end
  end

  // All-ones mode byte clears the keep state, as does any non-10 pair
  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      cont_q <= 1'b0;
    end else if (rise && st_q == D_MODE && adv) begin
      cont_q <= keep_nxt;
    end
  end

  // W7 and W3-0 are dropped; setting persists across commands
  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      wrap_hi_q <= 4'h0;
      wrap_q    <= `WRAP_RESET;
    end else if (rise && st_q == D_WRAP && cnt_q == `WRAP_HI_CLK) begin
      wrap_hi_q <= LINK.io;
    end else if (rise && st_q == D_WRAP && cnt_q == `WRAP_LO_CLK) begin
      wrap_q    <= wrap_hi_q[2:0];
    end
  end

  // Fetch ahead: first byte at data entry, next after each low nibble
  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      rd_q     <= 1'b0;
      rd_dly_q <= 1'b0;
    end else begin
      rd_q     <= data_go | byte_end;
      rd_dly_q <= rd_q;
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      data_q <= 8'h00;
    end else if (rd_dly_q) begin
      data_q <= MEM_DATA_IN;
    end
  end

  // While selected, outputs change on falling edges only; deselect clears them
  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN || !cs_act) begin
      lo_q   <= 1'b0;
      dout_q <= 4'h0;
      doe_q  <= 4'h0;
    end else if (fall && st_q == D_DATA) begin
      lo_q   <= ~lo_q;
      dout_q <= lo_q ? data_q[3:0] : data_q[7:4];
      doe_q  <= 4'hF;
    end
  end

  assign LINK.dev_io_out       = dout_q;
  assign LINK.dev_io_oe        = doe_q;
  assign MEM_ADDR_OUT          = addr_q;
  assign MEM_RD_OUT            = rd_q;
  assign WRAP_SETTING_BITS_OUT = wrap_q;
  assign CONT_READ_ACTIVE_OUT  = cont_q;
endmodule: qio_flash_end

// >>> core/qio_host_end.sv
// Purpose: host controller issuing quad I/O reads from AHB-Lite registers
// Assumes: single flash on the link, mode 0 clocking
// Notes:   received bytes pass a two-entry buffer; full buffer stops SCLK
//
// Decided for this implementation: the AHB-Lite slave port and the register offsets.
`timescale 1ns/100ps
`include "qio_cfg.svh"
module qio_host_end (
  // Clock and reset
  input  wire logic        SYS_CLK_IN,
  input  wire logic        RESET_IN,
  // AHB-Lite slave
  input  wire logic        HSEL_IN,
  input  wire logic [31:0] HADDR_IN,
  input  wire logic [1:0]  HTRANS_IN,
  input  wire logic        HWRITE_IN,
  input  wire logic [2:0]  HSIZE_IN,
  input  wire logic [31:0] HWDATA_IN,
  input  wire logic        HREADY_IN,
  output logic [31:0]      HRDATA_OUT,
  output logic             HREADYOUT_OUT,
  output logic             HRESP_OUT,
  // Serial link
  qio_link_if.host_mp      LINK
);
  import qio_pkg::*;

  host_state_e h_q;
  host_op_e    run_op_q;
  host_op_e    cont_op_q;
  logic [2:0]  op_q;
  logic        cont_req_q, run_cont_q, cont_q, go_q;
  logic [1:0]  init_q;
  logic [23:0] addr_q;
  logic [11:0] len_q;
  logic [12:0] cnt_q;
  logic [3:0]  div_q, hi_q, out_q, oe_q;
  logic        sclk_q, cs_n_q;
  logic [7:0]  opc_sh_q;
  logic [31:0] tx_q;
  logic        wr_q;
  logic [7:0]  wa_q;
  logic [31:0] rdata_q;
  logic [7:0]  fmem_q [2];
  logic        fwp_q, frp_q;
  logic [1:0]  fcnt_q;

  // Bus decode
  wire         take    = HSEL_IN & HTRANS_IN[1] & HREADY_IN;
  wire         rd_take = take & ~HWRITE_IN;
  wire [7:0]   ra      = HADDR_IN[7:0];
  wire         f_full  = fcnt_q == 2'h2;
  wire         f_empty = fcnt_q == 2'h0;
  wire         pop     = rd_take & (ra == `REG_RXDATA) & ~f_empty;
  wire         wr_ctrl = wr_q & (wa_q == `REG_CTRL);
  wire         idle    = h_q == H_IDLE;
  wire [31:0]  status  = {26'h0, fcnt_q, init_q == 2'h2, ~f_empty, cont_q, ~idle | go_q};
  wire [31:0]  rdata_d = (ra == `REG_CTRL)   ? {27'h0, op_q, cont_req_q, 1'b0} :
                         (ra == `REG_ADDR)   ? {8'h00, addr_q} :
                         (ra == `REG_LEN)    ? {20'h0, len_q} :
                         (ra == `REG_STATUS) ? status :
                         (ra == `REG_RXDATA) ? {24'h0, fmem_q[frp_q]} : 32'h0;

  // Wrap is forced off after reset, following a continuous-mode exit
  wire         init_done = init_q == 2'h2;
  wire host_op_e want = (init_q == 2'h0) ? OP_EXIT :
                        (init_q == 2'h1) ? OP_SETWRAP : host_op_e'(op_q);
  wire         want_go = ~init_done | go_q;
  wire         refuse  = cont_q & (want != OP_EXIT) & (want != cont_op_q);
  wire         start   = idle & want_go & ~refuse;
  wire         skip    = cont_q & (want == cont_op_q);
  wire         is_read = (want == OP_QREAD) | (want == OP_WREAD) | (want == OP_OREAD);
  wire [7:0]   opc     = (want == OP_QREAD) ? `OPC_QREAD : (want == OP_WREAD) ? `OPC_WREAD :
                         (want == OP_OREAD) ? `OPC_OREAD : `OPC_SETWRAP;
  wire [7:0]   wbyte   = init_done ? len_q[7:0] : `WRAP_OFF_BYTE;
  wire [7:0]   mbyte   = (cont_req_q & is_read) ? `MODE_CONT : `MODE_NORMAL;
  wire [23:0]  a_al    = (want == OP_WREAD) ? {addr_q[23:1], 1'b0} :
                         (want == OP_OREAD) ? {addr_q[23:4], 4'h0} : addr_q;
  wire [31:0]  tx_ld   = (want == OP_EXIT) ? `EXIT_WORD :
                         (want == OP_SETWRAP) ? {24'h0, wbyte} : {a_al, mbyte};
  wire host_state_e h_first = skip ? H_ADDR : (want == OP_EXIT) ? H_EXIT : H_OPC;

  // Phase lengths and sequencing
  wire [3:0]   dn      = (run_op_q == OP_QREAD) ? `DUMMY_QREAD :
                         (run_op_q == OP_WREAD) ? `DUMMY_WREAD : `DUMMY_OREAD;
  wire [11:0]  len_eff = (len_q == 12'h0) ? 12'h001 : len_q;
  wire [12:0]  lim     = (h_q == H_OPC)   ? {9'h0, `OPC_BITS} :
                         (h_q == H_ADDR)  ? {9'h0, `ADDR_NIBS} :
                         (h_q == H_MODE)  ? {9'h0, `MODE_NIBS} :
                         (h_q == H_DUMMY) ? {9'h0, dn} :
                         (h_q == H_DATA)  ? {len_eff, 1'b0} : {9'h0, `WRAP_CLKS};
  wire         last    = (cnt_q + 13'h1) == lim;
  wire host_state_e h_nx = (h_q == H_OPC) ? ((run_op_q == OP_SETWRAP) ? H_WRAP : H_ADDR) :
                           (h_q == H_ADDR) ? H_MODE :
                           (h_q == H_MODE) ? ((dn == `DUMMY_OREAD) ? H_DATA : H_DUMMY) :
                           (h_q == H_DUMMY) ? H_DATA : H_STOP;
  // Full buffer holds SCLK low, so no byte is ever dropped
  wire         stall   = (h_q == H_DATA) & f_full & ~sclk_q;
  wire         tick    = ~idle & (div_q == `SCK_HALF - 4'h1) & ~stall;
  wire         rise    = tick & ~sclk_q & (h_q != H_STOP);
  wire         fall    = tick & sclk_q;
  wire         push    = rise & (h_q == H_DATA) & cnt_q[0];
  wire         quad_tx = (h_q == H_ADDR) | (h_q == H_MODE) | (h_q == H_WRAP) | (h_q == H_EXIT);
  // IO lines released from the dummy phase on, ahead of device data
  wire [3:0]   nib     = (h_q == H_OPC) ? {3'h0, opc_sh_q[7]} : tx_q[31:28];
  wire [3:0]   nib_oe  = (h_q == H_OPC) ? 4'h1 : quad_tx ? 4'hF : 4'h0;

  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      wr_q    <= 1'b0;
      wa_q    <= 8'h00;
      rdata_q <= 32'h0;
    end else begin
      wr_q    <= take & HWRITE_IN;
      wa_q    <= ra;
      rdata_q <= rd_take ? rdata_d : rdata_q;
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      op_q <= 3'h0;
      cont_req_q <= 1'b0;
      addr_q <= 24'h0;
      len_q <= 12'h0;
    end else if (wr_ctrl) begin
      op_q <= HWDATA_IN[`CTRL_OP_MSB:`CTRL_OP_LSB];
      cont_req_q <= HWDATA_IN[`CTRL_CONT];
    end else if (wr_q && wa_q == `REG_ADDR) begin
      addr_q <= HWDATA_IN[23:0];
    end else if (wr_q && wa_q == `REG_LEN) begin
      len_q <= HWDATA_IN[11:0];
    end
  end

  // New go request wins over the clear of an older one
  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      go_q <= 1'b0;
      init_q <= 2'h0;
    end else begin
      go_q <= (wr_ctrl & HWDATA_IN[`CTRL_GO]) | (go_q & ~(idle & init_done));
      init_q <= (start && !init_done) ? init_q + 2'h1 : init_q;
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN || idle) begin
      div_q <= 4'h0;
    end else begin
      div_q <= (div_q == `SCK_HALF - 4'h1) ? 4'h0 : div_q + 4'h1;
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      h_q <= H_IDLE;
      cnt_q <= 13'h0;
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
      out_q <= 4'h0;
      oe_q <= 4'h0;
      run_op_q <= OP_QREAD;
      run_cont_q <= 1'b0;
      tx_q <= 32'h0;
      opc_sh_q <= 8'h00;
    end else if (start) begin
      h_q <= h_first;
      cnt_q <= 13'h0;
      cs_n_q <= 1'b0;
      run_op_q <= want;
      run_cont_q <= mbyte == `MODE_CONT;
      tx_q <= tx_ld;
      opc_sh_q <= opc;
      out_q <= (h_first == H_OPC) ? {3'h0, opc[7]} : tx_ld[31:28];
      oe_q <= (h_first == H_OPC) ? 4'h1 : 4'hF;
    end else if (rise) begin
      sclk_q <= 1'b1;
      cnt_q <= last ? 13'h0 : cnt_q + 13'h1;
      h_q <= last ? h_nx : h_q;
      tx_q <= quad_tx ? {tx_q[27:0], 4'h0} : tx_q;
      opc_sh_q <= {opc_sh_q[6:0], 1'b0};
    end else if (fall) begin
      sclk_q <= 1'b0;
      cs_n_q <= h_q == H_STOP;
      h_q <= (h_q == H_STOP) ? H_IDLE : h_q;
      out_q <= nib;
      oe_q <= nib_oe;
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      cont_q <= 1'b0;
      cont_op_q <= OP_QREAD;
    end else if (rise && last && h_q == H_MODE) begin
      cont_q <= run_cont_q;
      cont_op_q <= run_op_q;
    end else if (rise && last && h_q == H_EXIT) begin
      cont_q <= 1'b0;
    end
  end

  // Two-entry receive buffer
  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      hi_q <= 4'h0;
      fwp_q <= 1'b0;
      frp_q <= 1'b0;
      fcnt_q <= 2'h0;
      fmem_q[0] <= 8'h00;
      fmem_q[1] <= 8'h00;
    end else begin
      hi_q <= (rise && h_q == H_DATA && !cnt_q[0]) ? LINK.io : hi_q;
      if (push) begin
        fmem_q[fwp_q] <= {hi_q, LINK.io};
      end
      fwp_q <= fwp_q ^ push;
      frp_q <= frp_q ^ pop;
      fcnt_q <= fcnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  assign HRDATA_OUT       = rdata_q;
  assign HREADYOUT_OUT    = 1'b1;
  assign HRESP_OUT        = 1'b0;
  assign LINK.cs_n        = cs_n_q;
  assign LINK.sclk        = sclk_q;
  assign LINK.host_io_out = out_q;
  assign LINK.host_io_oe  = oe_q;
endmodule: qio_host_end

// >>> verif/qio_link_props.sv
// Purpose: link checks between the host and flash ends
// Assumes: link signals synchronous to SYS_CLK_IN
// Notes:   rise count clears while deselected
`timescale 1ns/100ps
module qio_link_props (
  // Clock and reset
  input wire logic       SYS_CLK_IN,
  input wire logic       RESET_IN,
  // Link
  input wire logic       cs_n,
  input wire logic       sclk,
  input wire logic [3:0] host_io_out,
  input wire logic [3:0] host_io_oe,
  input wire logic [3:0] dev_io_out,
  input wire logic [3:0] dev_io_oe,
  input wire logic [3:0] io
);
  logic [4:0] rise_q;
  logic       sclk_q;
  // Count of serial clock rises in the frame
  always_ff @(posedge SYS_CLK_IN) begin
    sclk_q <= sclk;
    rise_q <= (cs_n || RESET_IN) ? 5'h0 : rise_q + 5'(sclk && !sclk_q);
  end
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (RESET_IN);
  sequence s_high;
    sclk [*4] ##1 !sclk;
  endsequence
  sequence s_idle;
    cs_n [*3];
  endsequence
  a_no_fight: assert property ((host_io_oe & dev_io_oe) == 4'h0)
    else $error("both ends drive io");
  a_sclk_idle_low: assert property (cs_n |-> !sclk)
    else $error("sclk high while deselected");
  a_half_period: assert property ($rose(sclk) |-> s_high)
    else $error("sclk high phase not four cycles");
  a_dev_quiet: assert property (s_idle |-> dev_io_oe == 4'h0)
    else $error("device drives while deselected");
  a_host_quiet: assert property (cs_n [*2] |-> host_io_oe == 4'h0)
    else $error("host drives while deselected");
  a_idle_high: assert property (s_idle |-> io == 4'hF)
    else $error("idle io not high");
  a_host_release: assert property ($rose(|dev_io_oe) |-> $past(host_io_oe) == 4'h0)
    else $error("host still driving at data start");
  // Opcode 8, address 6, mode 2, then 4/2/0 dummies; a skipped opcode saves 8
  a_data_start: assert property ($rose(|dev_io_oe)
                                 |-> rise_q inside {8, 10, 12, 16, 18, 20})
    else $error("data start at wrong clock count");
  a_host_out_fall: assert property (!cs_n && !$fell(cs_n) && $changed(host_io_out)
                                    |-> $fell(sclk))
    else $error("host io changed off a falling edge");
  // Device sees the fall one cycle late, so its output moves a cycle after sclk
  a_dev_out_fall: assert property (!cs_n && |dev_io_oe && $changed(dev_io_out)
                                   |-> $past(sclk, 2) && !$past(sclk))
    else $error("device io changed off a falling edge");
endmodule: qio_link_props

// >>> verif/quad_io_read_xip_control_tb.sv
// Purpose: end-to-end bench of host and flash ends
// Assumes: zero-wait AHB-Lite slave, memory pattern model
// Notes:   every read fills the buffer before draining; reads over two bytes stall on it
`timescale 1ns/100ps
`include "qio_cfg.svh"
module quad_io_read_xip_control_tb;
  import qio_pkg::*;
  logic        clk, rst, hsel, hwrite, hready, hresp, qe, mem_rd, cont;
  logic [1:0]  htrans;
  logic [2:0]  hsize, wrap_bits, wrap_q;
  logic [31:0] haddr, hwdata, hrdata;
  logic [23:0] mem_addr;
  byte_t       mem_data;
  int          num_errors = 0;
  int          checked = 0;
  qio_link_if link ();
  qio_host_end u_qio_host_end (.SYS_CLK_IN(clk), .RESET_IN(rst), .HSEL_IN(hsel),
    .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(hsize),
    .HWDATA_IN(hwdata), .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready),
    .HRESP_OUT(hresp), .LINK(link));
  qio_flash_end u_qio_flash_end (.SYS_CLK_IN(clk), .RESET_IN(rst), .LINK(link),
    .QUAD_IO_ENABLE_BIT_IN(qe), .MEM_ADDR_OUT(mem_addr), .MEM_RD_OUT(mem_rd),
    .MEM_DATA_IN(mem_data), .WRAP_SETTING_BITS_OUT(wrap_bits), .CONT_READ_ACTIVE_OUT(cont));
  qio_link_props u_qio_link_props (.SYS_CLK_IN(clk), .RESET_IN(rst), .cs_n(link.cs_n),
    .sclk(link.sclk), .host_io_out(link.host_io_out), .host_io_oe(link.host_io_oe),
    .dev_io_out(link.dev_io_out), .dev_io_oe(link.dev_io_oe), .io(link.io));
  function automatic byte_t pat(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction: pat
  // Array answers one cycle after the fetch pulse
  always @(posedge clk) mem_data <= mem_rd ? pat(mem_addr) : 8'h00;
  task automatic finish_test();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask: finish_test
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask: chk
  // No wait limit here; only the watchdog ends a stuck transfer
  task automatic ready_edge();
    do begin
      @(posedge clk);
    end while (hready !== 1'b1);
  endtask: ready_edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    ready_edge();
    htrans <= 2'h0;
    hwdata <= wd;
    ready_edge();
    rd = hrdata;
  endtask: bus
  task automatic poll(input int bitn, input logic val);
    logic [31:0] s;
    int          n;
    n = 0;
    do begin
      bus(1'b0, `REG_STATUS, 32'h0, s);
      n++;
    end while (s[bitn] !== val && n < 3000);
    chk("status wait", 32'h1, 32'(n < 3000));
  endtask: poll
  task automatic rd_run(input logic [2:0] op, input logic [23:0] a, input int len, input logic c);
    logic [31:0] d;
    logic [23:0] b;
    logic [5:0]  m;
    m = 6'((8 << wrap_q[2:1]) - 1);
    bus(1'b1, `REG_ADDR, {8'h0, a}, d);
    bus(1'b1, `REG_LEN, 32'(len), d);
    bus(1'b1, `REG_CTRL, {27'h0, op, c, 1'b1}, d);
    // Let the buffer fill; reads over two bytes also stall the link
    repeat (400) @(posedge clk);
    bus(1'b0, `REG_STATUS, 32'h0, d);
    if (len > 1) chk("buffer count", 32'h2, {30'h0, d[5:4]});
    b = (op == 3'h1) ? {a[23:1], 1'b0} : (op == 3'h2) ? {a[23:4], 4'h0} : a;
    for (int i = 0; i < len; i++) begin
      poll(2, 1'b1);
      bus(1'b0, `REG_RXDATA, 32'h0, d);
      chk("rx byte", {24'h0, qe ? pat(b) : 8'hFF}, {24'h0, d[7:0]});
      // Wrap keeps the address inside its section
      b = (!wrap_q[0] && op != 3'h2) ? {b[23:6], (b[5:0] & ~m) | ((b[5:0] + 6'h1) & m)} : b + 24'h1;
    end
    poll(0, 1'b0);
  endtask: rd_run
  task automatic set_wrap(input byte_t w, input logic [2:0] exp);
    logic [31:0] d;
    bus(1'b1, `REG_LEN, {24'h0, w}, d);
    bus(1'b1, `REG_CTRL, 32'h0000000D, d);
    poll(0, 1'b0);
    chk("wrap bits", {29'h0, exp}, {29'h0, wrap_bits});
    wrap_q = exp;
  endtask: set_wrap
  task automatic t_init();
    poll(3, 1'b1);
    chk("wrap bits", 32'h1, {29'h0, wrap_bits});
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask: t_init
  task automatic t_reads();
    rd_run(3'h0, 24'h012345, 3, 1'b0);
    rd_run(3'h1, 24'h000203, 2, 1'b0);
    rd_run(3'h2, 24'h00031B, 2, 1'b0);
  endtask: t_reads
  task automatic t_wrap();
    set_wrap(8'hAF, 3'h2);
    rd_run(3'h0, 24'h00013C, 6, 1'b0);
    rd_run(3'h1, 24'h00023B, 8, 1'b0);
    set_wrap(8'h00, 3'h0);
    rd_run(3'h2, 24'h000140, 10, 1'b0);
    rd_run(3'h0, 24'h000146, 4, 1'b0);
    set_wrap(8'h10, 3'h1);
  endtask: t_wrap
  task automatic t_cont();
    logic [31:0] d;
    rd_run(3'h0, 24'h000400, 2, 1'b1);
    chk("cont", 32'h1, {31'h0, cont});
    bus(1'b0, `REG_STATUS, 32'h0, d);
    chk("cont view", 32'h1, {31'h0, d[1]});
    rd_run(3'h0, 24'h000500, 2, 1'b0);
    chk("cont", 32'h0, {31'h0, cont});
    rd_run(3'h2, 24'h000610, 2, 1'b1);
    bus(1'b1, `REG_CTRL, 32'h00000011, d);
    poll(0, 1'b0);
    chk("cont", 32'h0, {31'h0, cont});
  endtask: t_cont
  task automatic t_qe_off();
    qe <= 1'b0;
    rd_run(3'h0, 24'h000700, 2, 1'b0);
    qe <= 1'b1;
  endtask: t_qe_off
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    qe = 1'b1;
    wrap_q = 3'h1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_init();
    t_reads();
    t_wrap();
    t_cont();
    t_qe_off();
    finish_test();
  end
  // Run needs about 6k cycles
  initial begin
    #1500000;
    num_errors++;
    finish_test();
  end
endmodule: quad_io_read_xip_control_tb
